// file: src/ifc_pkg.sv
// How it works
// - Test register moves raise invalid opcode fault
// - Every reserved encoding raises invalid opcode fault
// - Feature high bits 0 and 15 set
// - Feature high bit 8 set
// - Feature high bit 4 set
// - Feature high bit 5 set
// - Feature low bits 11:8 read six
// - Flags bit 21 settable and clearable
// - Flags bit 18 writable, else zero
// - Flags bits 19, 20 zero without extensions
// - Stack pointer push stores pre-decrement value
// - Real mode stored flags: bit15 zero, 12-14 kept
package ifc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_OPCODE = 8'h08;
   localparam logic [7:0] ADDR_DEC_STAT = 8'h0C;
   localparam logic [7:0] ADDR_STACK = 8'h10;
   localparam logic [7:0] ADDR_PUSHED = 8'h14;
   localparam logic [7:0] ADDR_FEAT_LOW = 8'h18;
   localparam logic [7:0] ADDR_FEAT_HIGH = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h24;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h28;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_AC_IMPL = 0;
   localparam int CTRL_VME_IMPL = 1;
   localparam int CTRL_REAL_MODE = 2;
   localparam int FLG_AC = 18;
   localparam int FLG_VIF = 19;
   localparam int FLG_VIP = 20;
   localparam int FLG_ID = 21;
   localparam int FLG_RSV15 = 15;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_DONE = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and constants
   localparam logic [31:0] CTRL_RST = 32'h0000_0007;
   localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] STACK_RST = 32'h0000_0000;
   localparam logic [31:0] FLAGS_BASE_MASK = 32'h0023_7FD5;
   localparam logic [31:0] FEAT_LOW_VAL = 32'h0000_0600;
   localparam logic [31:0] FEAT_HIGH_VAL = 32'h0000_8131;
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] OP_ESCAPE = 8'h0F;
   localparam logic [7:0] OP_PUSH_SP = 8'h54;
   localparam logic [7:0] OP_PUSH_FLAGS = 8'h9C;

endpackage : ifc_pkg

// file: src/ifc_opcode_classify.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_opcode_classify
   import ifc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Request
   input wire logic req_i,
   input wire logic [15:0] opcode_i,
   // Registered result
   output logic valid_o,
   output logic fault_o,
   output logic testreg_o,
   output logic push_sp_o,
   output logic push_flags_o
);

   // Defined second bytes of the escape map
   function automatic logic esc_defined(input logic [7:0] b);
      esc_defined = (b <= 8'h03) || (b == 8'h06) || (b == 8'h08) || (b == 8'h09) ||
                    (b >= 8'h20 && b <= 8'h23) || (b >= 8'h30 && b <= 8'h33) ||
                    (b >= 8'h40 && b <= 8'h4F) || (b >= 8'h80 && b <= 8'hA5) ||
                    (b >= 8'hA8 && b <= 8'hB7) || (b >= 8'hB9 && b <= 8'hC1) ||
                    (b == 8'hC7) || (b >= 8'hC8);
   endfunction

   logic esc;
   logic tr;
   assign esc = (opcode_i[7:0] == OP_ESCAPE);
   assign tr = esc && ((opcode_i[15:8] == 8'h24) || (opcode_i[15:8] == 8'h26));

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         valid_o <= 1'b0;
         fault_o <= 1'b0;
         testreg_o <= 1'b0;
         push_sp_o <= 1'b0;
         push_flags_o <= 1'b0;
      end else begin
         valid_o <= req_i;
         testreg_o <= req_i && tr;
         fault_o <= req_i && (tr || (esc && !esc_defined(opcode_i[15:8])) ||
                    (!esc && (opcode_i[7:0] == 8'hD6 || opcode_i[7:0] == 8'hF1)));
         push_sp_o <= req_i && (opcode_i[7:0] == OP_PUSH_SP);
         push_flags_o <= req_i && (opcode_i[7:0] == OP_PUSH_FLAGS);
      end
   end

endmodule // ifc_opcode_classify
`default_nettype wire

// file: src/ifc_feature_core.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ifc_feature_core
   import ifc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Fault and interrupt
   output logic invalid_opcode_fault_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      apply_strb = r;
   endfunction

   function automatic logic [31:0] flags_wmask(input logic ac_impl, input logic vme_impl);
      logic [31:0] m;
      m = FLAGS_BASE_MASK;
      m[FLG_AC] = ac_impl;
      m[FLG_VIF] = vme_impl;
      m[FLG_VIP] = vme_impl;
      flags_wmask = m;
   endfunction

   function automatic logic [31:0] stack_image(input logic [31:0] flags, input logic real_mode);
      logic [31:0] r;
      r = flags;
      if (real_mode) begin
         r[FLG_RSV15] = 1'b0;
      end
      stack_image = r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= ADDR_IRQ_EN);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic wr_en;
   logic [31:0] wr_val;
   logic [31:0] op_wr;

   logic [31:0] ctrl_reg;
   logic [31:0] flags_reg;
   logic [31:0] stack_reg;
   logic [31:0] pushed_reg;
   logic [15:0] opcode_reg;
   logic dec_req_reg;
   logic [1:0] dec_stat_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_en_reg;
   logic fault_reg;

   logic res_valid;
   logic res_fault;
   logic res_testreg;
   logic res_push_sp;
   logic res_push_flags;
   logic [1:0] irq_events;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel

   assign s_axi_awready_o = !aw_full_reg;
   assign s_axi_wready_o = !w_full_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign wr_en = aw_full_reg && w_full_reg && !bvalid_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_axi_awvalid_i && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr_i;
      end else if (wr_en) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid_i && !w_full_reg) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata_i;
         w_strb_reg <= s_axi_wstrb_i;
      end else if (wr_en) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel

   assign s_axi_arready_o = !rvalid_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign s_axi_rdata_o = rdata_reg;

   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr_i)
         ADDR_CTRL: rdata_next = ctrl_reg;
         ADDR_FLAGS: rdata_next = flags_reg;
         ADDR_OPCODE: rdata_next = {16'h0000, opcode_reg};
         ADDR_DEC_STAT: rdata_next = {30'h0000_0000, dec_stat_reg};
         ADDR_STACK: rdata_next = stack_reg;
         ADDR_PUSHED: rdata_next = pushed_reg;
         ADDR_FEAT_LOW: rdata_next = FEAT_LOW_VAL;
         ADDR_FEAT_HIGH: rdata_next = FEAT_HIGH_VAL;
         ADDR_IRQ_STAT: rdata_next = {30'h0000_0000, irq_stat_reg};
         ADDR_IRQ_EN: rdata_next = {30'h0000_0000, irq_en_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (s_axi_arvalid_i && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         rdata_reg <= rdata_next;
      end else if (s_axi_rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and processor flags

   assign wr_val = w_data_reg;
   assign op_wr = apply_strb({16'h0000, opcode_reg}, wr_val, w_strb_reg);

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= CTRL_RST;
      end else if (wr_en && aw_addr_reg == ADDR_CTRL) begin
         ctrl_reg <= apply_strb(ctrl_reg, wr_val, w_strb_reg) & CTRL_RST;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         flags_reg <= FLAGS_RST;
      end else if (wr_en && aw_addr_reg == ADDR_FLAGS) begin
         flags_reg <= apply_strb(flags_reg, wr_val, w_strb_reg) &
                      flags_wmask(ctrl_reg[CTRL_AC_IMPL], ctrl_reg[CTRL_VME_IMPL]);
      end else begin
         flags_reg <= flags_reg & flags_wmask(ctrl_reg[CTRL_AC_IMPL], ctrl_reg[CTRL_VME_IMPL]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode request and classifier

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         opcode_reg <= 16'h0000;
         dec_req_reg <= 1'b0;
      end else begin
         dec_req_reg <= wr_en && aw_addr_reg == ADDR_OPCODE;
         if (wr_en && aw_addr_reg == ADDR_OPCODE) begin
            opcode_reg <= op_wr[15:0];
         end
      end
   end

   ifc_opcode_classify u_classify (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .req_i(dec_req_reg),
      .opcode_i(opcode_reg),
      .valid_o(res_valid),
      .fault_o(res_fault),
      .testreg_o(res_testreg),
      .push_sp_o(res_push_sp),
      .push_flags_o(res_push_flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Execute effects

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         fault_reg <= 1'b0;
         dec_stat_reg <= 2'h0;
      end else begin
         fault_reg <= res_valid && res_fault;
         if (res_valid) begin
            dec_stat_reg <= {res_testreg, res_fault};
         end
      end
   end

   assign invalid_opcode_fault_o = fault_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         stack_reg <= STACK_RST;
      end else if (res_valid && !res_fault && (res_push_sp || res_push_flags)) begin
         stack_reg <= stack_reg - STACK_STEP;
      end else if (wr_en && aw_addr_reg == ADDR_STACK) begin
         stack_reg <= apply_strb(stack_reg, wr_val, w_strb_reg);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         pushed_reg <= 32'h0000_0000;
      end else if (res_valid && !res_fault && res_push_sp) begin
         pushed_reg <= stack_reg;
      end else if (res_valid && (res_fault || res_push_flags)) begin
         pushed_reg <= stack_image(flags_reg, ctrl_reg[CTRL_REAL_MODE]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   assign irq_events = {res_valid, res_valid && res_fault};

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         irq_stat_reg <= 2'h0;
      end else if (wr_en && aw_addr_reg == ADDR_IRQ_CLR) begin
         irq_stat_reg <= (irq_stat_reg & ~wr_val[1:0]) | irq_events;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_events;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         irq_en_reg <= 2'h0;
      end else if (wr_en && aw_addr_reg == ADDR_IRQ_EN) begin
         irq_en_reg <= wr_val[1:0];
      end
   end

   assign irq_o = |(irq_stat_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_testreg_fault;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (res_valid && res_testreg) |=> invalid_opcode_fault_o && dec_stat_reg == 2'h3;
   endproperty
   a_testreg_fault: assert property (p_testreg_fault) else $error("test reg move no fault");

   property p_reserved_fault;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (res_valid && res_fault) |=> invalid_opcode_fault_o ##1 !invalid_opcode_fault_o;
   endproperty
   a_reserved_fault: assert property (p_reserved_fault) else $error("reserved op fault wrong");

   property p_feat_fp;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (s_axi_arvalid_i && !rvalid_reg && s_axi_araddr_i == ADDR_FEAT_HIGH) |=>
            s_axi_rdata_o[0] && s_axi_rdata_o[15];
   endproperty
   a_feat_fp: assert property (p_feat_fp) else $error("fp feature bits clear");

   property p_feat_cx8;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (s_axi_arvalid_i && !rvalid_reg && s_axi_araddr_i == ADDR_FEAT_HIGH) |=> s_axi_rdata_o[8];
   endproperty
   a_feat_cx8: assert property (p_feat_cx8) else $error("swap8 bit clear");

   property p_feat_tsc;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (s_axi_arvalid_i && !rvalid_reg && s_axi_araddr_i == ADDR_FEAT_HIGH) |=> s_axi_rdata_o[4];
   endproperty
   a_feat_tsc: assert property (p_feat_tsc) else $error("timestamp bit clear");

   property p_feat_msr;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (s_axi_arvalid_i && !rvalid_reg && s_axi_araddr_i == ADDR_FEAT_HIGH) |=> s_axi_rdata_o[5];
   endproperty
   a_feat_msr: assert property (p_feat_msr) else $error("model reg bit clear");

   property p_feat_low;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (s_axi_arvalid_i && !rvalid_reg && s_axi_araddr_i == ADDR_FEAT_LOW) |=>
            s_axi_rdata_o[11:8] == 4'h6;
   endproperty
   a_feat_low: assert property (p_feat_low) else $error("family field not six");

   property p_id_flag;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (wr_en && aw_addr_reg == ADDR_FLAGS && w_strb_reg[2]) |=> flags_reg[FLG_ID] == $past(w_data_reg[FLG_ID]);
   endproperty
   a_id_flag: assert property (p_id_flag) else $error("id flag not writable");

   property p_ac_flag;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         !ctrl_reg[CTRL_AC_IMPL] |=> !flags_reg[FLG_AC];
   endproperty
   a_ac_flag: assert property (p_ac_flag) else $error("ac flag set while absent");

   property p_vme_flags;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         !ctrl_reg[CTRL_VME_IMPL] |=> flags_reg[FLG_VIP:FLG_VIF] == 2'h0;
   endproperty
   a_vme_flags: assert property (p_vme_flags) else $error("virtual flags set while absent");

   property p_push_sp;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (res_valid && res_push_sp && !res_fault) |=>
            pushed_reg == $past(stack_reg) && stack_reg == $past(stack_reg) - STACK_STEP;
   endproperty
   a_push_sp: assert property (p_push_sp) else $error("push sp stored wrong value");

   property p_real_image;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
         (res_valid && (res_push_flags || res_fault) && ctrl_reg[CTRL_REAL_MODE]) |=>
            !pushed_reg[FLG_RSV15] && pushed_reg[14:12] == $past(flags_reg[14:12]);
   endproperty
   a_real_image: assert property (p_real_image) else $error("real mode flag image wrong");

endmodule // ifc_feature_core
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ifc_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, fault, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fail_count = 0;
   int n_compared = 0;
   int fault_cnt = 0;
   logic [31:0] seed = 32'hB1D2_2482;
   logic [31:0] flags_m = 32'h0, stack_m = 32'h0, pushed_m = 32'h0;
   logic [2:0] ctrl_m = 3'h7;
   logic [15:0] op_tab [10] = '{16'h240F, 16'h260F, 16'h00D6, 16'h00F1, 16'h040F,
                               16'hA60F, 16'h0054, 16'h009C, 16'hA20F, 16'h0090};
   logic [9:0] f_tab = 10'h03F;
   logic [9:0] t_tab = 10'h003;
   logic [1:0] stat_q[$];

   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (fault === 1'b1) fault_cnt <= fault_cnt + 1;

   ifc_feature_core dut (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .invalid_opcode_fault_o(fault), .irq_o(irq)
   );

   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // Writable flag bits for a given control setting
   function automatic logic [31:0] fmask(input logic [2:0] c);
      return 32'h0023_7FD5 | (c[0] ? 32'h0004_0000 : 32'h0) | (c[1] ? 32'h0018_0000 : 32'h0);
   endfunction

   // Stored flags image, bit 15 cleared in real mode
   function automatic logic [31:0] img();
      return flags_m & (ctrl_m[2] ? 32'hFFFF_7FFF : 32'hFFFF_FFFF);
   endfunction

   task automatic wrap_up();
      $display("Compared %0d values, %0d mismatches", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      fail_count++;
      wrap_up();
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk_sys_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 100) hang();
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int i;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk_sys_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 100) hang();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      chk(d, exp);
   endtask

   task automatic run_op(input logic [15:0] op, input logic f, input logic tr);
      int c0;
      logic [31:0] d;
      logic [1:0] r;
      c0 = fault_cnt;
      stat_q.push_back({tr, f});
      wr(ADDR_OPCODE, {16'h0, op});
      repeat (3) @(posedge clk_sys_i);
      chk(32'(fault_cnt - c0), {31'h0, f});
      axi_rd(ADDR_DEC_STAT, d, r);
      chk({30'h0, d[1:0]}, {30'h0, stat_q.pop_front()});
      if (f) begin
         pushed_m = img();
      end else if (op == 16'h0054) begin
         pushed_m = stack_m;
         stack_m -= 32'h4;
      end else if (op == 16'h009C) begin
         pushed_m = img();
         stack_m -= 32'h4;
      end
      rd_chk(ADDR_PUSHED, pushed_m);
      rd_chk(ADDR_STACK, stack_m);
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (20) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      chk({29'h0, awready, wready, arready}, 32'h7);
      chk({28'h0, bvalid, rvalid, fault, irq}, 32'h0);
      rd_chk(ADDR_CTRL, 32'h0000_0007);
      rd_chk(ADDR_FLAGS, 32'h0);
      rd_chk(ADDR_STACK, 32'h0);
      rd_chk(ADDR_PUSHED, 32'h0);
      rd_chk(ADDR_IRQ_STAT, 32'h0);
      rd_chk(ADDR_IRQ_EN, 32'h0);
      wr(ADDR_FEAT_LOW, 32'hFFFF_FFFF);
      rd_chk(ADDR_FEAT_LOW, 32'h0000_0600);
      axi_rd(ADDR_FEAT_HIGH, d, r);
      chk({31'h0, d[0] & d[15]}, 32'h1);
      chk({31'h0, d[8]}, 32'h1);
      chk({31'h0, d[4]}, 32'h1);
      chk({31'h0, d[5]}, 32'h1);
      axi_rd(8'h2C, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(d, 32'h0);
      axi_wr(8'h06, 32'hFFFF_FFFF, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      $display("Test reset_and_features finished");
      wr(ADDR_FLAGS, 32'h0020_0000);
      rd_chk(ADDR_FLAGS, 32'h0020_0000);
      wr(ADDR_FLAGS, 32'h0);
      rd_chk(ADDR_FLAGS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         ctrl_m = 3'(i);
         wr(ADDR_CTRL, {29'h0, ctrl_m});
         seed = xs(seed);
         flags_m = seed & fmask(ctrl_m);
         wr(ADDR_FLAGS, seed);
         rd_chk(ADDR_FLAGS, flags_m);
      end
      ctrl_m = 3'h7;
      wr(ADDR_CTRL, 32'h7);
      wr(ADDR_FLAGS, 32'hFFFF_FFFF);
      ctrl_m = 3'h4;
      wr(ADDR_CTRL, 32'h4);
      flags_m = 32'hFFFF_FFFF & fmask(ctrl_m);
      rd_chk(ADDR_FLAGS, flags_m);
      wstrb <= 4'h4;
      wr(ADDR_FLAGS, 32'h0);
      wstrb <= 4'hF;
      flags_m = flags_m & 32'hFF00_FFFF;
      rd_chk(ADDR_FLAGS, flags_m);
      $display("Test flags finished");
      stack_m = 32'h0000_0100;
      wr(ADDR_STACK, stack_m);
      for (int j = 0; j < 2; j++) begin
         ctrl_m = j ? 3'h3 : 3'h7;
         wr(ADDR_CTRL, {29'h0, ctrl_m});
         seed = xs(seed);
         flags_m = (seed | 32'h0000_7000) & fmask(ctrl_m);
         wr(ADDR_FLAGS, seed | 32'h0000_7000);
         for (int i = 0; i < 10; i++)
            run_op(op_tab[i], f_tab[i], t_tab[i]);
      end
      $display("Test decode finished");
      wr(ADDR_IRQ_CLR, 32'h3);
      rd_chk(ADDR_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_EN, 32'h1);
      run_op(16'h00D6, 1'b1, 1'b0);
      chk({31'h0, irq}, 32'h1);
      rd_chk(ADDR_IRQ_STAT, 32'h3);
      rd_chk(ADDR_IRQ_CLR, 32'h0);
      wr(ADDR_IRQ_EN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_EN, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_CLR, 32'h2);
      chk({31'h0, irq}, 32'h0);
      rd_chk(ADDR_IRQ_STAT, 32'h1);
      $display("Test interrupt finished");
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
